// File: rtl/asrt_pkg.sv
// Package: register map, field layout and timing constants of the serial core
package asrt_pkg;
	localparam int             ASRT_AW         = 3;
	localparam logic [2:0]     ASRT_FRAME_OFF  = 3'h0;
	localparam logic [2:0]     ASRT_BAUD_OFF   = 3'h1;
	localparam logic [2:0]     ASRT_OPT_OFF    = 3'h2;
	localparam logic [2:0]     ASRT_STAT_OFF   = 3'h3;
	localparam logic [2:0]     ASRT_TXD_OFF    = 3'h4;
	localparam logic [2:0]     ASRT_RXD_OFF    = 3'h5;
	// Frame format control fields
	localparam int             ASRT_PWR_BIT    = 7;
	localparam int             ASRT_TXE_BIT    = 6;
	localparam int             ASRT_RXE_BIT    = 5;
	localparam int             ASRT_DIR_BIT    = 4;
	localparam int             ASRT_PAR_LSB    = 2;
	localparam int             ASRT_LEN_BIT    = 1;
	localparam int             ASRT_STP_BIT    = 0;
	// Line option fields
	localparam int             ASRT_TXINV_BIT  = 1;
	localparam int             ASRT_RXINV_BIT  = 0;
	// Status fields
	localparam int             ASRT_TSF_BIT    = 7;
	localparam int             ASRT_PE_BIT     = 2;
	localparam int             ASRT_FE_BIT     = 1;
	localparam int             ASRT_OVE_BIT    = 0;
	// Reset values
	localparam logic [7:0]     ASRT_FRAME_RST  = 8'h01;
	localparam logic [7:0]     ASRT_BAUD_RST   = 8'hff;
	localparam logic [7:0]     ASRT_OPT_RST    = 8'h00;
	localparam logic [7:0]     ASRT_RXD_RST    = 8'hff;
	// Noise filter depth: two stored samples, which must equal the live one
	localparam int             ASRT_FILT_N     = 2;
	typedef enum logic [1:0] {
		ASRT_PAR_NONE = 2'h0,
		ASRT_PAR_ZERO = 2'h1,
		ASRT_PAR_ODD  = 2'h2,
		ASRT_PAR_EVEN = 2'h3
	} asrt_par_e;
endpackage : asrt_pkg

// File: rtl/asrt_cfg_if.sv
// Interface: receive enable and input inversion shared by the core and its receive filter
`timescale 1ns/100ps
interface asrt_cfg_if;
	logic rxInvert;
	logic rxEnable;
	modport core (output rxInvert, output rxEnable);
	modport filt (input rxInvert, input rxEnable);
endinterface : asrt_cfg_if

// File: rtl/asrt_rx_filter.sv
// Receive input noise filter: three equal samples (two stored, one live) move the output
`timescale 1ns/100ps
module asrt_rx_filter
	import asrt_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Settings
	asrt_cfg_if.filt  cfg,
	// Line
	input  wire logic serialIn,
	output logic      filtered
);
	typedef struct packed {
		logic [ASRT_FILT_N-1:0] smp;
		logic                   out;
	} asrt_filt_s;

	asrt_filt_s st_q;
	asrt_filt_s st_d;

	// Output moves only when the stored samples match the live one or receive is disabled (held high), so pulses of two clocks never pass
	always_comb begin
		logic inBit;
		inBit = serialIn ^ cfg.rxInvert;
		st_d = st_q;
		st_d.smp = {st_q.smp[ASRT_FILT_N-2:0], inBit};
		if (st_q.smp == {ASRT_FILT_N{inBit}}) begin
			st_d.out = inBit;
		end
		if (!cfg.rxEnable) begin
			st_d.out = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '{smp: '1, out: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign filtered = st_q.out;
endmodule : asrt_rx_filter

// File: rtl/asrt_serial_core.sv
// Asynchronous serial transmit and receive core with register port
//
// How it works
// - Transmitter runs only with power and transmit-enable
// - Holding write starts framed serial transmission
// - Transmit request pulses on holding-to-shift transfer
// - Holding register refills while current word shifts
// - Receiver runs only with power and receive-enable
// - Start accepted if low half bit after edge
// - Shift bits in, copy to data register at stop
// - Overrun drops new word, sets overrun flag
// - Parity or framing error still stores word
// - Errors give status request, not receive-complete
// - Unread data register causes overrun next word
// - Only one stop bit checked on receive
// - Error flags sticky until written zero
// - Even, odd, zero and no parity modes
// - Three-sample noise filter on receive input
`timescale 1ns/100ps
module asrt_serial_core
	import asrt_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Register port
	input  wire logic [ASRT_AW-1:0] regAddr,
	input  wire logic [7:0]         regWdata,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic      [7:0]         regRdata,
	// Serial line
	input  wire logic               serialInPin,
	output logic                    serialOutPin,
	// Requests
	output logic                    txIrq,
	output logic                    rxCompleteIrq,
	output logic                    statusIrq
);
	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_DATA  = 4'h4,
		TX_TAIL  = 4'h8
	} asrt_tx_e;
	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} asrt_rx_e;

	typedef struct packed {
		logic [7:0] frame;
		logic [7:0] baud;
		logic [7:0] opt;
		logic [7:0] rdata;
		// Transmit side
		asrt_tx_e   txSt;
		logic [7:0] hold;
		logic       holdFull;
		logic [9:0] txShift;
		logic [3:0] txBits;
		logic [7:0] txCnt;
		logic       txOut;
		logic       txIrq;
		logic       txPin;
		// Receive side
		asrt_rx_e   rxSt;
		logic       rxPrev;
		logic [8:0] rxShift;
		logic [3:0] rxBits;
		logic [7:0] rxCnt;
		logic [7:0] rxData;
		logic       rxUnread;
		logic       pe;
		logic       fe;
		logic       ove;
		logic       rcIrq;
		logic       stIrq;
	} asrt_core_s;

	asrt_core_s st_q;
	asrt_core_s st_d;
	logic       rxLine;
	asrt_cfg_if cfgBus ();

	logic      pwr, txOn, rxOn, lsbFirst, len8, stop2;
	asrt_par_e par;
	logic [7:0] halfBaud;
	logic [3:0] dataBits;
	logic       rxPar, rxPe, rxFe;

	assign pwr      = st_q.frame[ASRT_PWR_BIT];
	assign txOn     = pwr & st_q.frame[ASRT_TXE_BIT];
	assign rxOn     = pwr & st_q.frame[ASRT_RXE_BIT];
	assign lsbFirst = st_q.frame[ASRT_DIR_BIT];
	assign par      = asrt_par_e'(st_q.frame[ASRT_PAR_LSB +: 2]);
	assign len8     = st_q.frame[ASRT_LEN_BIT];
	assign stop2    = st_q.frame[ASRT_STP_BIT];
	assign halfBaud = {1'b0, st_q.baud[7:1]};
	assign dataBits = len8 ? 4'h8 : 4'h7;

	assign cfgBus.rxInvert = st_q.opt[ASRT_RXINV_BIT];
	assign cfgBus.rxEnable = rxOn;

	asrt_rx_filter u_filt (
		.clk      (clk),
		.rst      (rst),
		.cfg      (cfgBus.filt),
		.serialIn (serialInPin),
		.filtered (rxLine)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] orderWord(input logic [7:0] w, input logic lsb, input logic l8);
		logic [7:0] r;
		r = w;
		if (!lsb) begin
			r = l8 ? {<<{w}} : {1'b0, {<<{w[6:0]}}};
		end
		return r;
	endfunction : orderWord

	function automatic logic parBit(input logic [7:0] w, input logic l8, input asrt_par_e p);
		logic ones;
		ones = ^(l8 ? w : {1'b0, w[6:0]});
		case (p)
			ASRT_PAR_ODD:  parBit = ~ones;
			ASRT_PAR_EVEN: parBit = ones;
			default:       parBit = 1'b0;
		endcase
	endfunction : parBit

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] w;
		logic [7:0] rw;
		w  = 8'h00;
		rw = 8'h00;
		rxPar = 1'b0;
		rxPe  = 1'b0;
		rxFe  = 1'b0;
		st_d = st_q;
		st_d.txIrq = 1'b0;
		st_d.rcIrq = 1'b0;
		st_d.stIrq = 1'b0;
		st_d.rxPrev = rxLine;

		// Register writes
		if (regWr) begin
			case (regAddr)
				ASRT_FRAME_OFF: st_d.frame = regWdata;
				ASRT_BAUD_OFF:  st_d.baud  = regWdata;
				ASRT_OPT_OFF:   st_d.opt   = regWdata;
				ASRT_STAT_OFF: begin
					// Writing zero clears a flag; new events below still win
					st_d.pe  = st_q.pe  & regWdata[ASRT_PE_BIT];
					st_d.fe  = st_q.fe  & regWdata[ASRT_FE_BIT];
					st_d.ove = st_q.ove & regWdata[ASRT_OVE_BIT];
				end
				ASRT_TXD_OFF: begin
					if (txOn) begin
						st_d.hold     = regWdata;
						st_d.holdFull = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (regRd && regAddr == ASRT_RXD_OFF) begin
			st_d.rxUnread = 1'b0;
		end

		// ------------------------------------------------------------
		// Transmitter
		// ------------------------------------------------------------
		st_d.txCnt = (st_q.txCnt == 8'h00) ? st_q.baud : st_q.txCnt - 8'h01;
		case (st_q.txSt)
			TX_IDLE: begin
				st_d.txOut = 1'b1;
				st_d.txCnt = st_q.baud;
				if (st_q.holdFull) begin
					w = orderWord(st_q.hold, lsbFirst, len8);
					st_d.txShift  = {1'b1, parBit(st_q.hold, len8, par), w};
					// A write landing in the transfer cycle keeps the holding register full
					st_d.holdFull = regWr && (regAddr == ASRT_TXD_OFF);
					st_d.txIrq    = 1'b1;
					st_d.txOut    = 1'b0;
					st_d.txSt     = TX_START;
				end
			end
			TX_START: begin
				if (st_q.txCnt == 8'h00) begin
					st_d.txOut   = st_q.txShift[0];
					st_d.txShift = {1'b1, st_q.txShift[9:1]};
					st_d.txBits  = dataBits - 4'h1;
					st_d.txSt    = TX_DATA;
				end
			end
			TX_DATA: begin
				if (st_q.txCnt == 8'h00) begin
					if (st_q.txBits != 4'h0) begin
						st_d.txOut   = st_q.txShift[0];
						st_d.txShift = {1'b1, st_q.txShift[9:1]};
						st_d.txBits  = st_q.txBits - 4'h1;
					end else begin
						// Skip past the unused 8th slot for 7-bit words
						if (!len8) begin
							st_d.txShift = {1'b1, st_q.txShift[9:1]};
						end
						st_d.txOut  = (par == ASRT_PAR_NONE) ? 1'b1 : st_d.txShift[0];
						st_d.txBits = 4'(par != ASRT_PAR_NONE) + 4'(stop2);
						st_d.txSt   = TX_TAIL;
					end
				end
			end
			TX_TAIL: begin
				if (st_q.txCnt == 8'h00) begin
					st_d.txOut = 1'b1;
					if (st_q.txBits != 4'h0) begin
						st_d.txBits = st_q.txBits - 4'h1;
					end else begin
						st_d.txSt = TX_IDLE;
					end
				end
			end
			default: st_d.txSt = TX_IDLE;
		endcase
		if (!txOn) begin
			st_d.txSt     = TX_IDLE;
			st_d.txOut    = 1'b1;
			st_d.holdFull = 1'b0;
		end

		// ------------------------------------------------------------
		// Receiver
		// ------------------------------------------------------------
		st_d.rxCnt = (st_q.rxCnt == 8'h00) ? st_q.baud : st_q.rxCnt - 8'h01;
		case (st_q.rxSt)
			RX_IDLE: begin
				st_d.rxCnt = halfBaud;
				if (st_q.rxPrev && !rxLine) begin
					st_d.rxSt = RX_START;
				end
			end
			RX_START: begin
				if (st_q.rxCnt == 8'h00) begin
					st_d.rxSt   = rxLine ? RX_IDLE : RX_DATA;
					st_d.rxBits = dataBits + 4'(par != ASRT_PAR_NONE);
				end
			end
			RX_DATA: begin
				if (st_q.rxCnt == 8'h00) begin
					st_d.rxShift = {rxLine, st_q.rxShift[8:1]};
					st_d.rxBits  = st_q.rxBits - 4'h1;
					if (st_q.rxBits == 4'h1) begin
						st_d.rxSt = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				// One stop bit only; a second one is treated as idle line
				if (st_q.rxCnt == 8'h00) begin
					if (par != ASRT_PAR_NONE) begin
						rxPar = st_q.rxShift[8];
						rw    = len8 ? st_q.rxShift[7:0] : {1'b0, st_q.rxShift[7:1]};
					end else begin
						rw = len8 ? st_q.rxShift[8:1] : {1'b0, st_q.rxShift[8:2]};
					end
					rxPe = (par == ASRT_PAR_ODD || par == ASRT_PAR_EVEN) && (parBit(rw, len8, par) != rxPar);
					rxFe = !rxLine;
					st_d.rxSt = RX_IDLE;
					if (st_q.rxUnread) begin
						st_d.ove   = 1'b1;
						st_d.stIrq = 1'b1;
					end else begin
						st_d.rxData   = orderWord(rw, lsbFirst, len8);
						st_d.rxUnread = 1'b1;
						if (rxPe || rxFe) begin
							st_d.stIrq = 1'b1;
						end else begin
							st_d.rcIrq = 1'b1;
						end
					end
					if (rxPe) begin
						st_d.pe = 1'b1;
					end
					if (rxFe) begin
						st_d.fe = 1'b1;
					end
				end
			end
			default: st_d.rxSt = RX_IDLE;
		endcase
		if (!rxOn) begin
			st_d.rxSt = RX_IDLE;
		end

		// ------------------------------------------------------------
		// Read data, one cycle after the strobe
		// ------------------------------------------------------------
		st_d.rdata = 8'h00;
		if (regRd) begin
			case (regAddr)
				ASRT_FRAME_OFF: st_d.rdata = st_q.frame;
				ASRT_BAUD_OFF:  st_d.rdata = st_q.baud;
				ASRT_OPT_OFF:   st_d.rdata = st_q.opt;
				ASRT_STAT_OFF: begin
					st_d.rdata[ASRT_TSF_BIT] = (st_q.txSt != TX_IDLE) | st_q.holdFull;
					st_d.rdata[ASRT_PE_BIT]  = st_q.pe;
					st_d.rdata[ASRT_FE_BIT]  = st_q.fe;
					st_d.rdata[ASRT_OVE_BIT] = st_q.ove;
				end
				ASRT_TXD_OFF:   st_d.rdata = st_q.hold;
				ASRT_RXD_OFF:   st_d.rdata = st_q.rxData;
				default:        st_d.rdata = 8'h00;
			endcase
		end
		st_d.txPin = st_d.txOut ^ st_d.opt[ASRT_TXINV_BIT];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q          <= '0;
			st_q.frame    <= ASRT_FRAME_RST;
			st_q.baud     <= ASRT_BAUD_RST;
			st_q.opt      <= ASRT_OPT_RST;
			st_q.rxData   <= ASRT_RXD_RST;
			st_q.txSt     <= TX_IDLE;
			st_q.rxSt     <= RX_IDLE;
			st_q.txOut    <= 1'b1;
			st_q.txPin    <= 1'b1;
			st_q.rxPrev   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign regRdata      = st_q.rdata;
	assign serialOutPin  = st_q.txPin;
	assign txIrq         = st_q.txIrq;
	assign rxCompleteIrq = st_q.rcIrq;
	assign statusIrq     = st_q.stIrq;
endmodule : asrt_serial_core

// File: test/asrt_serial_core_chk.sv
// Checker: port-level timing of the serial core
`timescale 1ns/100ps
module asrt_serial_core_chk
	import asrt_pkg::*;
(
	// Clock, reset and register port
	input wire logic               clk,
	input wire logic               rst,
	input wire logic [ASRT_AW-1:0] regAddr,
	input wire logic [7:0]         regWdata,
	input wire logic               regWr,
	input wire logic               regRd,
	input wire logic [7:0]         regRdata,
	// Line and requests
	input wire logic               serialInPin,
	input wire logic               serialOutPin,
	input wire logic               txIrq,
	input wire logic               rxCompleteIrq,
	input wire logic               statusIrq
);
	logic [7:0]  frameQ;
	logic [7:0]  baudQ;
	logic [7:0]  optQ;
	logic        pendQ;
	logic [15:0] txCntQ;
	int          bitLen;
	logic        statRd;
	assign bitLen = int'(baudQ) + 1;
	assign statRd = regRd & (regAddr == ASRT_STAT_OFF);
	// ----------------------------------------
	// Shadow settings, pending word, cycles since transmit request
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameQ <= ASRT_FRAME_RST;
			baudQ  <= ASRT_BAUD_RST;
			optQ   <= ASRT_OPT_RST;
			pendQ  <= 1'b0;
			txCntQ <= 16'hffff;
		end else begin
			if (regWr && regAddr == ASRT_FRAME_OFF) frameQ <= regWdata;
			if (regWr && regAddr == ASRT_BAUD_OFF) baudQ <= regWdata;
			if (regWr && regAddr == ASRT_OPT_OFF) optQ <= regWdata;
			if (txIrq) pendQ <= 1'b0;
			else if (regWr && regAddr == ASRT_TXD_OFF && frameQ[ASRT_PWR_BIT] && frameQ[ASRT_TXE_BIT]) pendQ <= 1'b1;
			txCntQ <= txIrq ? 16'h0001 : txCntQ + {15'h0000, ~&txCntQ};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_tx_start; txIrq |-> serialOutPin == optQ[ASRT_TXINV_BIT]; endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start bit with request");
	property p_tx_cause; txIrq |-> pendQ; endproperty
	a_tx_cause: assert property (p_tx_cause) else $error("request without word");
	property p_tx_enable; txIrq |-> frameQ[ASRT_PWR_BIT] && frameQ[ASRT_TXE_BIT]; endproperty
	a_tx_enable: assert property (p_tx_enable) else $error("transmit while disabled");
	property p_tx_gap; txIrq |-> txCntQ >= 9 * bitLen; endproperty
	a_tx_gap: assert property (p_tx_gap) else $error("frames overlap");
	property p_tx_idle; txCntQ >= 12 * bitLen && !pendQ |-> serialOutPin != optQ[ASRT_TXINV_BIT]; endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("line not idle");
	property p_busy; statRd && txCntQ <= 16'(baudQ) |=> regRdata[ASRT_TSF_BIT]; endproperty
	a_busy: assert property (p_busy) else $error("busy flag low in frame");
	property p_rx_en; rxCompleteIrq || statusIrq |-> frameQ[ASRT_PWR_BIT] && frameQ[ASRT_RXE_BIT]; endproperty
	a_rx_en: assert property (p_rx_en) else $error("receive while disabled");
	property p_rx_excl; rxCompleteIrq |-> !statusIrq; endproperty
	a_rx_excl: assert property (p_rx_excl) else $error("both receive requests");
endmodule : asrt_serial_core_chk
bind asrt_serial_core asrt_serial_core_chk chk (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
	.txIrq(txIrq), .rxCompleteIrq(rxCompleteIrq), .statusIrq(statusIrq));

// File: test/asrt_remote_node.sv
// Remote serial node: sends frames to the core and captures its frames
`timescale 1ns/100ps
module asrt_remote_node #(
	parameter int BIT = 8
) (
	// Clock
	input  wire logic   clk,
	// Line
	input  wire logic   lineIn,
	output logic        lineOut,
	// Last captured frame
	output logic [10:0] gotFrame,
	output int          gotCount
);
	initial begin
		lineOut  = 1'b1;
		gotFrame = '0;
		gotCount = 0;
	end
	// Start, data LSB first, even parity (or its inverse), one stop
	task automatic send_word(input logic [7:0] d, input logic badPar);
		logic [10:0] f;
		f = {1'b1, (^d) ^ badPar, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			lineOut <= f[i];
			repeat (BIT - 1) @(posedge clk);
		end
	endtask : send_word
	task automatic glitch(input int n);
		@(posedge clk);
		lineOut <= 1'b0;
		repeat (n) @(posedge clk);
		lineOut <= 1'b1;
	endtask : glitch
	// Samples eleven bit cells at mid-bit after each falling edge
	always begin
		@(negedge lineIn);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 11; i++) begin
			gotFrame[i] = lineIn;
			if (i < 10) repeat (BIT) @(posedge clk);
		end
		gotCount++;
	end
endmodule : asrt_remote_node

// File: test/test_asrt_serial_core.sv
// Testbench: register and line scenarios for the serial core
`timescale 1ns/100ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s expected %h seen %h", n, e, g); end end
module test_asrt_serial_core
	import asrt_pkg::*;
;
	localparam int         BIT = 8;
	localparam logic [7:0] RST_TAB [8] = '{ASRT_FRAME_RST, ASRT_BAUD_RST, ASRT_OPT_RST, 8'h00, 8'h00,
		ASRT_RXD_RST, 8'h00, 8'h00};
	logic               clk;
	logic               rst = 1'b1;
	logic [ASRT_AW-1:0] regAddr = '0;
	logic [7:0]         regWdata = '0;
	logic               regWr = 1'b0;
	logic               regRd = 1'b0;
	logic [7:0]         regRdata;
	logic               serialInPin;
	logic               serialOutPin;
	logic               txIrq;
	logic               rxCompleteIrq;
	logic               statusIrq;
	logic [10:0]        gotFrame;
	logic [10:0]        expFrame;
	logic [7:0]         d;
	int                 gotCount;
	int                 fails = 0;
	int                 samplesChecked = 0;
	int                 txIrqs = 0;
	int                 rxIrqs = 0;
	int                 stIrqs = 0;
	int                 n;
	asrt_serial_core dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
		.txIrq(txIrq), .rxCompleteIrq(rxCompleteIrq), .statusIrq(statusIrq));
	asrt_remote_node #(.BIT(BIT)) node (.clk(clk), .lineIn(serialOutPin), .lineOut(serialInPin),
		.gotFrame(gotFrame), .gotCount(gotCount));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (txIrq === 1'b1) txIrqs++;
		if (rxCompleteIrq === 1'b1) rxIrqs++;
		if (statusIrq === 1'b1) stIrqs++;
	end
	// ----------------------------------------
	// Register port and waiting tasks
	// ----------------------------------------
	task automatic wr(input logic [ASRT_AW-1:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= v;
		regWr    <= 1'b1;
		@(posedge clk);
		regWr    <= 1'b0;
	endtask : wr
	task automatic rdChk(input logic [ASRT_AW-1:0] a, input logic [7:0] e, input string s);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd   <= 1'b0;
		#1;
		`CHK(s, e, regRdata)
	endtask : rdChk
	task automatic giveVerdict();
		$display("comparisons %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : giveVerdict
	task automatic waitFor(input int sel, input int cnt);
		int k;
		for (k = 0; k < 4000; k++) begin
			@(posedge clk);
			#1;
			if ((sel == 0 ? txIrqs : sel == 1 ? rxIrqs + stIrqs : gotCount) >= cnt) break;
		end
		if (k == 4000) begin
			fails++;
			$display("[ERR] wait expected event seen none");
			giveVerdict();
		end
	endtask : waitFor
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) if (i != 4) rdChk(ASRT_AW'(i), RST_TAB[i], "reset value");
		$display("reset values done");
		wr(ASRT_BAUD_OFF, 8'h07);
		wr(ASRT_OPT_OFF, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(ASRT_FRAME_OFF, 8'h00);
			// Mode 1 sends MSB first, mode 2 seven bits, mode 3 two stop bits
			wr(ASRT_FRAME_OFF, {3'h7, 1'(m != 1), 2'(m), (m == 2) ? 2'b00 : (m == 3) ? 2'b11 : 2'b10});
			d = (m == 0) ? 8'h81 : (m == 2) ? 8'h83 : 8'h07;
			case (m)
				0: expFrame = {2'b11, d, 1'b0};
				1: expFrame = {2'b10, 8'he0, 1'b0};
				2: expFrame = {2'b11, ~^d[6:0], d[6:0], 1'b0};
				default: expFrame = {1'b1, ^d, d, 1'b0};
			endcase
			n = gotCount + 1;
			wr(ASRT_TXD_OFF, d);
			waitFor(2, n);
			`CHK("tx frame", expFrame, gotFrame)
			repeat (2 * BIT) @(posedge clk);
			rdChk(ASRT_STAT_OFF, 8'h00, "idle after frame");
		end
		$display("parity modes done");
		n = gotCount;
		wr(ASRT_TXD_OFF, 8'ha5);
		waitFor(0, 5);
		rdChk(ASRT_STAT_OFF, 8'h80, "busy flag");
		wr(ASRT_TXD_OFF, 8'h3c);
		waitFor(2, n + 1);
		expFrame = {1'b1, ^8'ha5, 8'ha5, 1'b0};
		`CHK("first frame", expFrame, gotFrame)
		repeat (2 * BIT) @(posedge clk);
		`CHK("next start", 6, txIrqs)
		waitFor(2, n + 2);
		expFrame = {1'b1, ^8'h3c, 8'h3c, 1'b0};
		`CHK("second frame", expFrame, gotFrame)
		repeat (2 * BIT) @(posedge clk);
		rdChk(ASRT_STAT_OFF, 8'h00, "idle flag");
		wr(ASRT_FRAME_OFF, 8'h00);
		wr(ASRT_FRAME_OFF, 8'hae);
		wr(ASRT_TXD_OFF, 8'h55);
		repeat (12 * BIT) @(posedge clk);
		`CHK("tx disabled", 6, txIrqs)
		`CHK("line idle", 1'b1, serialOutPin)
		$display("transmit done");
		wr(ASRT_FRAME_OFF, 8'h00);
		wr(ASRT_FRAME_OFF, 8'hfe);
		node.send_word(8'h5a, 1'b0);
		waitFor(1, 1);
		rdChk(ASRT_RXD_OFF, 8'h5a, "rx word");
		`CHK("rx complete", 1, rxIrqs)
		node.send_word(8'h33, 1'b1);
		waitFor(1, 2);
		`CHK("status request", 1, stIrqs)
		rdChk(ASRT_STAT_OFF, 8'h04, "parity flag");
		rdChk(ASRT_RXD_OFF, 8'h33, "word kept");
		wr(ASRT_STAT_OFF, 8'h00);
		rdChk(ASRT_STAT_OFF, 8'h00, "flag cleared");
		$display("receive done");
		// One-clock bits make the half-bit check immediate, so only the filter can stop the pulse
		wr(ASRT_FRAME_OFF, 8'h00);
		wr(ASRT_BAUD_OFF, 8'h00);
		wr(ASRT_FRAME_OFF, 8'hfe);
		node.glitch(2);
		repeat (12 * BIT) @(posedge clk);
		`CHK("glitch ignored", 2, rxIrqs + stIrqs)
		wr(ASRT_FRAME_OFF, 8'h00);
		wr(ASRT_BAUD_OFF, 8'h07);
		wr(ASRT_FRAME_OFF, 8'hfe);
		$display("filter done");
		node.send_word(8'h11, 1'b0);
		node.send_word(8'h22, 1'b0);
		waitFor(1, 4);
		rdChk(ASRT_STAT_OFF, 8'h01, "overrun flag");
		rdChk(ASRT_RXD_OFF, 8'h11, "old word");
		`CHK("overrun request", 2, stIrqs)
		wr(ASRT_FRAME_OFF, 8'h00);
		$display("overrun done");
		wr(ASRT_OPT_OFF, 8'h02);
		@(posedge clk);
		#1;
		`CHK("inverted idle", 1'b0, serialOutPin)
		$display("polarity done");
		giveVerdict();
	end
endmodule : test_asrt_serial_core
